//--- pkg/codec_io_pkg.sv
// Register map, field layout and reset values of the codec audio and pin control bank
package codec_io_pkg;

  // Printed offsets are register indices; byte address is four times the index
  localparam logic [7:0] PIN_IO_CONTROL_IDX = 8'h06;
  localparam logic [7:0] AUDIO_LOOPBACK_CONTROL_IDX = 8'h08;
  localparam logic [7:0] AUDIO_GAIN_CONTROL_IDX = 8'h09;
  localparam logic [7:0] LINE_IMPEDANCE_CONTROL_IDX = 8'h0A;
  localparam logic [11:0] PIN_IO_CONTROL_ADDR = 12'h018;
  localparam logic [11:0] AUDIO_LOOPBACK_CONTROL_ADDR = 12'h020;
  localparam logic [11:0] AUDIO_GAIN_CONTROL_ADDR = 12'h024;
  localparam logic [11:0] LINE_IMPEDANCE_CONTROL_ADDR = 12'h028;

  // Pin control fields
  localparam int OUT_PIN_LEVEL_BIT = 4;
  localparam int GP_PIN_TWO_DIRECTION_BIT = 3;
  localparam int GP_PIN_ONE_DIRECTION_BIT = 2;
  localparam int GP_PIN_TWO_VALUE_BIT = 1;
  localparam int GP_PIN_ONE_VALUE_BIT = 0;

  // Loopback fields
  localparam int FULL_ANALOG_LOOPBACK_BIT = 2;
  localparam int DIGITAL_LOOPBACK_BIT = 1;
  localparam int FIRST_ANALOG_LOOPBACK_BIT = 0;

  // Gain fields
  localparam int RX_HIGHPASS_BYPASS_BIT = 7;
  localparam int TX_HIGHPASS_BYPASS_BIT = 6;
  localparam int TX_DIGITAL_MUTE_BIT = 5;
  localparam int RX_DIGITAL_MUTE_BIT = 4;
  localparam int ANALOG_TX_GAIN_LSB = 2;
  localparam int ANALOG_RX_GAIN_LSB = 0;

  // Impedance fields
  localparam int LINE_CAP_COMPENSATION_LSB = 4;
  localparam int IMPEDANCE_SYNTHESIS_ENABLE_BIT = 3;
  localparam int IMPEDANCE_SYNTHESIS_SELECT_LSB = 0;

  // Writable bits per register
  localparam logic [7:0] PIN_IO_CONTROL_MASK = 8'h1F;
  localparam logic [7:0] AUDIO_LOOPBACK_CONTROL_MASK = 8'h07;
  localparam logic [7:0] AUDIO_GAIN_CONTROL_MASK = 8'hFF;
  localparam logic [7:0] LINE_IMPEDANCE_CONTROL_MASK = 8'h3F;

  // Reset values
  localparam logic [7:0] PIN_IO_CONTROL_RESET = 8'h00;
  localparam logic [7:0] AUDIO_LOOPBACK_CONTROL_RESET = 8'h00;
  localparam logic [7:0] AUDIO_GAIN_CONTROL_RESET = 8'h00;
  localparam logic [7:0] LINE_IMPEDANCE_CONTROL_RESET = 8'h00;

  // Analog gain codes
  localparam logic [1:0] GAIN_0DB = 2'h0;
  localparam logic [1:0] GAIN_MINUS_3P5DB = 2'h1;
  localparam logic [1:0] GAIN_PLUS_3P5DB = 2'h2;
  localparam logic [1:0] GAIN_MUTED = 2'h3;

  // Line capacitance compensation codes
  localparam logic [1:0] LINE_CAP_OFF = 2'h0;
  localparam logic [1:0] LINE_CAP_4N7 = 2'h1;
  localparam logic [1:0] LINE_CAP_10N = 2'h2;
  localparam logic [1:0] LINE_CAP_RESERVED = 2'h3;

endpackage

//--- hw/codec_audio_io_control.sv
// APB register bank for codec pin control, loopback, gain and impedance settings
// Function
// RL1 - Bit 4 sets dedicated output pin level
// RL2 - Bit 3 sets pin two direction
// RL3 - Bit 2 sets pin one direction
// RL4 - Bit 1 drives or reads pin two
// RL5 - Bit 0 drives or reads pin one
// RL6 - Loopback bit 2 enables full analog loopback
// RL7 - Loopback bit 1 enables digital loopback
// RL8 - Loopback bit 0 enables first analog loopback
// RL9 - Gain bit 7 bypasses receive highpass filter
// RL10 - Gain bit 6 bypasses transmit highpass filter
// RL11 - Gain bit 5 mutes transmit digitally
// RL12 - Gain bit 4 mutes receive digitally
// RL13 - Bits 3:2 set analog transmit gain
// RL14 - Bits 1:0 set analog receive gain
// RL15 - Impedance bits 5:4 select line compensation
// RL16 - Impedance bit 3 enables impedance synthesis
// RL17 - Impedance bits 2:0 select synthesized impedance
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
`default_nettype none

module codec_audio_io_control (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Dedicated output pin
  output logic out_pin_level,
  // General-purpose pin one
  input wire logic gp_pin_one_in,
  output logic gp_pin_one_out,
  output logic gp_pin_one_oe,
  // General-purpose pin two
  input wire logic gp_pin_two_in,
  output logic gp_pin_two_out,
  output logic gp_pin_two_oe,
  // Loopback controls
  output logic full_analog_loopback,
  output logic digital_loopback,
  output logic first_analog_loopback,
  // Audio path controls
  output logic rx_highpass_bypass,
  output logic tx_highpass_bypass,
  output logic tx_digital_mute,
  output logic rx_digital_mute,
  output logic [1:0] analog_tx_gain,
  output logic [1:0] analog_rx_gain,
  output logic analog_tx_path_mute,
  output logic analog_rx_path_mute,
  // Line impedance controls
  output logic [1:0] line_cap_compensation,
  output logic impedance_synthesis_enable,
  output logic [2:0] impedance_synthesis_select
);

  typedef struct packed {
    logic [1:0] pin_one_sync;
    logic [1:0] pin_two_sync;
    logic [7:0] pin_io_control;
    logic [7:0] audio_loopback_control;
    logic [7:0] audio_gain_control;
    logic [7:0] line_impedance_control;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic out_pin_level;
    logic gp_pin_one_out;
    logic gp_pin_one_oe;
    logic gp_pin_two_out;
    logic gp_pin_two_oe;
    logic full_analog_loopback;
    logic digital_loopback;
    logic first_analog_loopback;
    logic rx_highpass_bypass;
    logic tx_highpass_bypass;
    logic tx_digital_mute;
    logic rx_digital_mute;
    logic [1:0] analog_tx_gain;
    logic [1:0] analog_rx_gain;
    logic analog_tx_path_mute;
    logic analog_rx_path_mute;
    logic [1:0] line_cap_compensation;
    logic impedance_synthesis_enable;
    logic [2:0] impedance_synthesis_select;
  } state_t;

  localparam state_t RESET_STATE = '{
    pin_one_sync: 2'h0,
    pin_two_sync: 2'h0,
    pin_io_control: codec_io_pkg::PIN_IO_CONTROL_RESET,
    audio_loopback_control: codec_io_pkg::AUDIO_LOOPBACK_CONTROL_RESET,
    audio_gain_control: codec_io_pkg::AUDIO_GAIN_CONTROL_RESET,
    line_impedance_control: codec_io_pkg::LINE_IMPEDANCE_CONTROL_RESET,
    prdata: 32'h0000_0000,
    pready: 1'b0,
    pslverr: 1'b0,
    out_pin_level: 1'b0,
    gp_pin_one_out: 1'b0,
    gp_pin_one_oe: 1'b0,
    gp_pin_two_out: 1'b0,
    gp_pin_two_oe: 1'b0,
    full_analog_loopback: 1'b0,
    digital_loopback: 1'b0,
    first_analog_loopback: 1'b0,
    rx_highpass_bypass: 1'b0,
    tx_highpass_bypass: 1'b0,
    tx_digital_mute: 1'b0,
    rx_digital_mute: 1'b0,
    analog_tx_gain: 2'h0,
    analog_rx_gain: 2'h0,
    analog_tx_path_mute: 1'b0,
    analog_rx_path_mute: 1'b0,
    line_cap_compensation: 2'h0,
    impedance_synthesis_enable: 1'b0,
    impedance_synthesis_select: 3'h0
  };

  state_t state;
  state_t next_state;

  // Write a byte register honouring the low byte strobe
  function automatic logic [7:0] merge_byte(input logic [7:0] old_value, input logic [7:0] new_value,
                                            input logic [7:0] mask, input logic lane);
    merge_byte = lane ? (new_value & mask) : old_value;
  endfunction

  always_comb begin
    logic access;
    logic mapped;
    logic [7:0] wbyte;
    logic [7:0] pin_read;
    logic [7:0] rdbyte;
    logic [1:0] tx_code;
    logic [1:0] rx_code;
    access = 1'b0;
    mapped = 1'b0;
    wbyte = 8'h00;
    pin_read = 8'h00;
    rdbyte = 8'h00;
    tx_code = 2'h0;
    rx_code = 2'h0;
    next_state = state;

    // Pin inputs pass two flops before anything reads them
    next_state.pin_one_sync = {state.pin_one_sync[0], gp_pin_one_in};
    next_state.pin_two_sync = {state.pin_two_sync[0], gp_pin_two_in};

    // One wait state per access: pready rises two cycles after setup starts
    access = psel && penable && !state.pready;
    wbyte = pwdata[7:0];
    mapped = (paddr == codec_io_pkg::PIN_IO_CONTROL_ADDR) ||
             (paddr == codec_io_pkg::AUDIO_LOOPBACK_CONTROL_ADDR) ||
             (paddr == codec_io_pkg::AUDIO_GAIN_CONTROL_ADDR) ||
             (paddr == codec_io_pkg::LINE_IMPEDANCE_CONTROL_ADDR);
    next_state.pready = access;
    next_state.pslverr = access && !mapped;

    if (access && pwrite && mapped) begin
      unique case (paddr)
        codec_io_pkg::PIN_IO_CONTROL_ADDR: begin
          next_state.pin_io_control = merge_byte(state.pin_io_control, wbyte,
                                                 codec_io_pkg::PIN_IO_CONTROL_MASK, pstrb[0]);
        end
        codec_io_pkg::AUDIO_LOOPBACK_CONTROL_ADDR: begin
          next_state.audio_loopback_control = merge_byte(state.audio_loopback_control, wbyte,
                                                         codec_io_pkg::AUDIO_LOOPBACK_CONTROL_MASK, pstrb[0]);
        end
        codec_io_pkg::AUDIO_GAIN_CONTROL_ADDR: begin
          next_state.audio_gain_control = merge_byte(state.audio_gain_control, wbyte,
                                                     codec_io_pkg::AUDIO_GAIN_CONTROL_MASK, pstrb[0]);
        end
        default: begin
          next_state.line_impedance_control = merge_byte(state.line_impedance_control, wbyte,
                                                         codec_io_pkg::LINE_IMPEDANCE_CONTROL_MASK, pstrb[0]);
        end
      endcase
    end

    // Input pins read back their synchronised level instead of the stored bit
    pin_read = state.pin_io_control;
    if (!state.pin_io_control[codec_io_pkg::GP_PIN_TWO_DIRECTION_BIT]) begin
      pin_read[codec_io_pkg::GP_PIN_TWO_VALUE_BIT] = state.pin_two_sync[1]; // RL4
    end
    if (!state.pin_io_control[codec_io_pkg::GP_PIN_ONE_DIRECTION_BIT]) begin
      pin_read[codec_io_pkg::GP_PIN_ONE_VALUE_BIT] = state.pin_one_sync[1]; // RL5
    end

    if (paddr == codec_io_pkg::PIN_IO_CONTROL_ADDR) begin
      rdbyte = pin_read;
    end else if (paddr == codec_io_pkg::AUDIO_LOOPBACK_CONTROL_ADDR) begin
      rdbyte = state.audio_loopback_control;
    end else if (paddr == codec_io_pkg::AUDIO_GAIN_CONTROL_ADDR) begin
      rdbyte = state.audio_gain_control;
    end else if (paddr == codec_io_pkg::LINE_IMPEDANCE_CONTROL_ADDR) begin
      rdbyte = state.line_impedance_control;
    end else begin
      rdbyte = 8'h00;
    end
    next_state.prdata = (access && !pwrite) ? {24'h00_0000, rdbyte} : 32'h0000_0000;

    // Outputs follow the registers one cycle after a write lands
    next_state.out_pin_level = state.pin_io_control[codec_io_pkg::OUT_PIN_LEVEL_BIT]; // RL1
    next_state.gp_pin_two_oe = state.pin_io_control[codec_io_pkg::GP_PIN_TWO_DIRECTION_BIT]; // RL2
    next_state.gp_pin_one_oe = state.pin_io_control[codec_io_pkg::GP_PIN_ONE_DIRECTION_BIT]; // RL3
    next_state.gp_pin_two_out = state.pin_io_control[codec_io_pkg::GP_PIN_TWO_VALUE_BIT]; // RL4
    next_state.gp_pin_one_out = state.pin_io_control[codec_io_pkg::GP_PIN_ONE_VALUE_BIT]; // RL5

    next_state.full_analog_loopback =
      state.audio_loopback_control[codec_io_pkg::FULL_ANALOG_LOOPBACK_BIT]; // RL6
    next_state.digital_loopback = state.audio_loopback_control[codec_io_pkg::DIGITAL_LOOPBACK_BIT]; // RL7
    next_state.first_analog_loopback =
      state.audio_loopback_control[codec_io_pkg::FIRST_ANALOG_LOOPBACK_BIT]; // RL8

    next_state.rx_highpass_bypass = state.audio_gain_control[codec_io_pkg::RX_HIGHPASS_BYPASS_BIT]; // RL9
    next_state.tx_highpass_bypass = state.audio_gain_control[codec_io_pkg::TX_HIGHPASS_BYPASS_BIT]; // RL10
    next_state.tx_digital_mute = state.audio_gain_control[codec_io_pkg::TX_DIGITAL_MUTE_BIT]; // RL11
    next_state.rx_digital_mute = state.audio_gain_control[codec_io_pkg::RX_DIGITAL_MUTE_BIT]; // RL12

    tx_code = state.audio_gain_control[codec_io_pkg::ANALOG_TX_GAIN_LSB +: 2];
    rx_code = state.audio_gain_control[codec_io_pkg::ANALOG_RX_GAIN_LSB +: 2];
    // Transmit mute code keeps 0 dB gain with the path muted
    next_state.analog_tx_gain = (tx_code == codec_io_pkg::GAIN_MUTED) ? codec_io_pkg::GAIN_0DB : tx_code; // RL13
    next_state.analog_tx_path_mute = (tx_code == codec_io_pkg::GAIN_MUTED); // RL13
    next_state.analog_rx_gain = rx_code; // RL14
    next_state.analog_rx_path_mute = (rx_code == codec_io_pkg::GAIN_MUTED); // RL14

    // Reserved compensation code is stored but drives compensation off
    next_state.line_cap_compensation =
      (state.line_impedance_control[codec_io_pkg::LINE_CAP_COMPENSATION_LSB +: 2] == codec_io_pkg::LINE_CAP_RESERVED)
      ? codec_io_pkg::LINE_CAP_OFF
      : state.line_impedance_control[codec_io_pkg::LINE_CAP_COMPENSATION_LSB +: 2]; // RL15
    next_state.impedance_synthesis_enable =
      state.line_impedance_control[codec_io_pkg::IMPEDANCE_SYNTHESIS_ENABLE_BIT]; // RL16
    next_state.impedance_synthesis_select =
      state.line_impedance_control[codec_io_pkg::IMPEDANCE_SYNTHESIS_SELECT_LSB +: 3]; // RL17
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= RESET_STATE;
    end else begin
      state <= next_state;
    end
  end

  assign prdata = state.prdata;
  assign pready = state.pready;
  assign pslverr = state.pslverr;
  assign out_pin_level = state.out_pin_level;
  assign gp_pin_one_out = state.gp_pin_one_out;
  assign gp_pin_one_oe = state.gp_pin_one_oe;
  assign gp_pin_two_out = state.gp_pin_two_out;
  assign gp_pin_two_oe = state.gp_pin_two_oe;
  assign full_analog_loopback = state.full_analog_loopback;
  assign digital_loopback = state.digital_loopback;
  assign first_analog_loopback = state.first_analog_loopback;
  assign rx_highpass_bypass = state.rx_highpass_bypass;
  assign tx_highpass_bypass = state.tx_highpass_bypass;
  assign tx_digital_mute = state.tx_digital_mute;
  assign rx_digital_mute = state.rx_digital_mute;
  assign analog_tx_gain = state.analog_tx_gain;
  assign analog_rx_gain = state.analog_rx_gain;
  assign analog_tx_path_mute = state.analog_tx_path_mute;
  assign analog_rx_path_mute = state.analog_rx_path_mute;
  assign line_cap_compensation = state.line_cap_compensation;
  assign impedance_synthesis_enable = state.impedance_synthesis_enable;
  assign impedance_synthesis_select = state.impedance_synthesis_select;

endmodule

`default_nettype wire

//--- dv/codec_audio_io_control_assertions.sv
// Checker for bus timing and output coding of the codec control bank
`timescale 1ns/1ps
`default_nettype none
module codec_audio_io_control_checker (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Outputs
  input wire logic out_pin_level,
  input wire logic gp_pin_one_oe,
  input wire logic gp_pin_two_oe,
  input wire logic [1:0] analog_tx_gain,
  input wire logic [1:0] analog_rx_gain,
  input wire logic analog_tx_path_mute,
  input wire logic analog_rx_path_mute,
  input wire logic [1:0] line_cap_compensation
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_take;
    psel && penable && !pready;
  endsequence
  sequence s_pin_wr;
    s_take ##0 (pwrite && pstrb[0] && paddr == codec_io_pkg::PIN_IO_CONTROL_ADDR);
  endsequence
  property p_answer;
    s_take |=> pready;
  endproperty
  property p_pulse;
    pready |=> !pready;
  endproperty
  property p_err;
    pslverr |-> pready;
  endproperty
  property p_idle;
    !pready |-> prdata == 32'h00000000;
  endproperty
  // Outputs lag the register by one cycle
  property p_pin;
    s_pin_wr |=> ##1 (out_pin_level == $past(pwdata[4], 2) && gp_pin_two_oe == $past(pwdata[3], 2)
      && gp_pin_one_oe == $past(pwdata[2], 2));
  endproperty
  property p_tx_mute;
    analog_tx_path_mute |-> analog_tx_gain == 2'h0;
  endproperty
  property p_rx_mute;
    analog_rx_path_mute == (analog_rx_gain == 2'h3);
  endproperty
  property p_cap;
    line_cap_compensation != 2'h3;
  endproperty
  a_answer: assert property (p_answer) else $error("no answer after access");
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  a_err: assert property (p_err) else $error("error without ready");
  a_idle: assert property (p_idle) else $error("read data outside ready");
  a_pin: assert property (p_pin) else $error("pin outputs wrong");
  a_tx_mute: assert property (p_tx_mute) else $error("tx mute gain wrong");
  a_rx_mute: assert property (p_rx_mute) else $error("rx mute wrong");
  a_cap: assert property (p_cap) else $error("reserved compensation driven");
endmodule
bind codec_audio_io_control codec_audio_io_control_checker codec_audio_io_control_checker_i (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
  .out_pin_level, .gp_pin_one_oe, .gp_pin_two_oe, .analog_tx_gain, .analog_rx_gain,
  .analog_tx_path_mute, .analog_rx_path_mute, .line_cap_compensation);
`default_nettype wire

//--- dv/codec_audio_io_control_tb.sv
// Self-checking bench for the codec control register bank
`timescale 1ns/1ps
`default_nettype none
module codec_audio_io_control_tb;
  localparam logic [11:0] PIN = codec_io_pkg::PIN_IO_CONTROL_ADDR;
  localparam logic [11:0] LOOP = codec_io_pkg::AUDIO_LOOPBACK_CONTROL_ADDR;
  localparam logic [11:0] GAIN = codec_io_pkg::AUDIO_GAIN_CONTROL_ADDR;
  localparam logic [11:0] IMP = codec_io_pkg::LINE_IMPEDANCE_CONTROL_ADDR;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'h0;
  logic gp_pin_one_in = 1'b0, gp_pin_two_in = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, out_pin_level, gp_pin_one_out, gp_pin_one_oe, gp_pin_two_out, gp_pin_two_oe;
  logic full_analog_loopback, digital_loopback, first_analog_loopback, analog_tx_path_mute;
  logic rx_highpass_bypass, tx_highpass_bypass, tx_digital_mute, rx_digital_mute, analog_rx_path_mute;
  logic [1:0] analog_tx_gain, analog_rx_gain, line_cap_compensation;
  logic impedance_synthesis_enable;
  logic [2:0] impedance_synthesis_select;
  int err_total = 0;
  int check_count = 0;
  always #5 pclk = ~pclk;
  codec_audio_io_control codec_audio_io_control_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .out_pin_level, .gp_pin_one_in, .gp_pin_one_out,
    .gp_pin_one_oe, .gp_pin_two_in, .gp_pin_two_out, .gp_pin_two_oe, .full_analog_loopback,
    .digital_loopback, .first_analog_loopback, .rx_highpass_bypass, .tx_highpass_bypass, .tx_digital_mute,
    .rx_digital_mute, .analog_tx_gain, .analog_rx_gain, .analog_tx_path_mute, .analog_rx_path_mute,
    .line_cap_compensation, .impedance_synthesis_enable, .impedance_synthesis_select);
  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One transfer; waits for ready with a bound instead of a fixed latency
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
                     output logic [31:0] rd, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) err_total++;
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] rd;
    logic e;
    apb(1'b1, a, d, 4'h1, rd, e);
    chk("write error", 32'(e), 32'h0);
    repeat (2) @(posedge pclk);
  endtask
  task automatic rdc(input string name, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic e;
    apb(1'b0, a, 8'h00, 4'h0, rd, e);
    chk(name, rd, exp);
  endtask
  task automatic t_pins;
    rdc("pin reset", PIN, 32'h0);
    wr(PIN, 8'hFF);
    chk("pin drive high", 32'({out_pin_level, gp_pin_two_oe, gp_pin_one_oe, gp_pin_two_out, gp_pin_one_out}),
        32'h1F);
    rdc("pin read out", PIN, 32'h1F);
    gp_pin_one_in <= 1'b1;
    wr(PIN, 8'h02);
    chk("pin input mode", 32'({out_pin_level, gp_pin_two_oe, gp_pin_one_oe}), 32'h0);
    rdc("pin read in", PIN, 32'h01);
    gp_pin_two_in <= 1'b1;
    wr(PIN, 8'h0D);
    chk("pin drive mix", 32'({gp_pin_two_oe, gp_pin_one_oe, gp_pin_two_out, gp_pin_one_out}), 32'hD);
    rdc("pin read stored", PIN, 32'h0D);
  endtask
  task automatic t_loop;
    for (int i = 0; i < 3; i++) begin
      wr(LOOP, 8'(1 << i) | 8'hF8);
      chk("loop outs", 32'({full_analog_loopback, digital_loopback, first_analog_loopback}), 32'(1 << i));
      rdc("loop read", LOOP, 32'(1 << i));
    end
  endtask
  task automatic t_gain;
    logic [7:0] v;
    for (int k = 0; k < 4; k++) begin
      v = {4'(1 << k), 2'(k), 2'(3 - k)};
      wr(GAIN, v);
      chk("gain bits", 32'({rx_highpass_bypass, tx_highpass_bypass, tx_digital_mute, rx_digital_mute}),
          32'(v[7:4]));
      chk("tx gain", 32'({analog_tx_path_mute, analog_tx_gain}), k == 3 ? 32'h4 : 32'(k));
      chk("rx gain", 32'({analog_rx_path_mute, analog_rx_gain}), k == 0 ? 32'h7 : 32'(3 - k));
      rdc("gain read", GAIN, 32'(v));
    end
  endtask
  task automatic t_imp;
    logic [7:0] v;
    for (int k = 0; k < 8; k++) begin
      v = {2'h3, 2'(k), k[0], 3'(k)};
      wr(IMP, v);
      chk("cap comp", 32'(line_cap_compensation), k % 4 == 3 ? 32'h0 : 32'(k % 4));
      chk("synthesis", 32'({impedance_synthesis_enable, impedance_synthesis_select}), 32'(v[3:0]));
      rdc("imp read", IMP, 32'(v & 8'h3F));
    end
  endtask
  // Unmapped places and a write whose strobe is off
  task automatic t_bus;
    logic [31:0] rd;
    logic e;
    apb(1'b0, 12'h01C, 8'h00, 4'h0, rd, e);
    chk("unmapped data", rd, 32'h0);
    chk("unmapped read err", 32'(e), 32'h1);
    apb(1'b1, 12'h02C, 8'hFF, 4'h1, rd, e);
    chk("unmapped write err", 32'(e), 32'h1);
    rdc("imp kept", IMP, 32'h3F);
    apb(1'b1, GAIN, 8'h00, 4'h0, rd, e);
    rdc("gain kept", GAIN, 32'h8C);
  endtask
  // Reset in mid-run clears every register and output; input pins still read back
  task automatic t_reset;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("outputs after reset", 32'({out_pin_level, gp_pin_one_out, gp_pin_one_oe, gp_pin_two_out, gp_pin_two_oe,
        full_analog_loopback, digital_loopback, first_analog_loopback, rx_highpass_bypass, tx_highpass_bypass,
        tx_digital_mute, rx_digital_mute, analog_tx_gain, analog_rx_gain, analog_tx_path_mute,
        analog_rx_path_mute, line_cap_compensation, impedance_synthesis_enable, impedance_synthesis_select}),
        32'h0);
    rdc("loop after reset", LOOP, 32'h0);
    rdc("gain after reset", GAIN, 32'h0);
    rdc("imp after reset", IMP, 32'h0);
    rdc("pin after reset", PIN, 32'h03);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_pins;
    t_loop;
    t_gain;
    t_imp;
    t_bus;
    t_reset;
    final_report;
  end
  // Whole run is a few hundred cycles
  initial begin
    repeat (5000) @(posedge pclk);
    err_total++;
    final_report;
  end
endmodule
`default_nettype wire
